// *** logic/spmc_serial_ctrl.sv ***
// Purpose: Port function select, second control register, I2C master engine
// Assumes: Single 200 MHz core_clk, synchronous active-low reset
// Notes: SPI shifting is not built here; slave side handles 7-bit receive
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Four-bit code selects SPI or I2C function
// - Master operation never sets receive overflow
// - General call interrupts only when enabled
// - Ack status shows the acknowledge slot of the last transmitted byte
// - Ack level bit sets driven acknowledge
// - Ack sequence enable runs, then self-clears
// - Receive enable clocks in one byte
// - Stop enable makes Stop, then self-clears
// - Repeated start enable runs, then self-clears
// - Start enable makes Start, then self-clears
// - In slave mode start bit enables stretching
// - All control bits reset to zero
// - Busy unit ignores go bits and buffer writes
module spmc_serial_ctrl (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOe,
	input wire logic serialClockIn,
	output logic serialClockOut,
	output logic serialClockOe,
	output logic irq
);
	typedef enum logic [2:0] {
		M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK
	} spmc_mstate_t;
	typedef enum logic [1:0] {S_IDLE, S_SHIFT, S_ACK, S_HOLD} spmc_sstate_t;

	spmc_mstate_t mState;
	spmc_sstate_t sState;
	logic [3:0] portFunctionSelect;
	logic portEnable, receiveOverflowFlag;
	logic generalCallEnable, ackLevelBit, ackStatusFlag;
	logic [4:0] goReg;
	logic [7:0] dividerOrAddressReg, transferBuffer, txByte, rxShift;
	logic [7:0] receiveShifter;
	logic bufFull, txGo;
	logic [1:0] irqStat, irqMask, phase;
	logic [3:0] bitCnt, sCnt;
	logic [7:0] divCnt;
	logic mSdaLow, mSclLow, sSdaLow, sSclLow, addrPhase;
	logic sdaMeta, sdaS, sdaP, sclMeta, sclS, sclP;
	logic masterMode, slaveMode, busy, tick, lastBit, seqDone;
	logic wrFire, wrCtrl2, wrBuf, rdBuf, sclRise, sclFall;
	logic startDet, stopDet, addrMatch, sByteDone, sAccept;
	logic [7:0] rdByte;
	logic rdHit, wrHit;

	// ------------------------------------------------------------
	// Mode decode and pins
	// ------------------------------------------------------------
	// mode select
	assign masterMode = portEnable
		&& portFunctionSelect == spmc_pkg::MODE_I2C_MASTER;
	assign slaveMode = portEnable
		&& portFunctionSelect == spmc_pkg::MODE_I2C_SLAVE7;
	assign busy = mState != M_IDLE || goReg[4:1] != 4'h0 || txGo
		|| (masterMode && goReg[spmc_pkg::C2_SEN]);
	// Open drain: the pins are only ever pulled low
	assign serialDataOut = 1'b0;
	assign serialClockOut = 1'b0;
	assign serialDataOe = mSdaLow | sSdaLow;
	assign serialClockOe = mSclLow | sSclLow;
	assign irq = |(irqStat & irqMask);

	// The second and third stages feed the rest of the logic
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			{sdaMeta, sdaS, sdaP} <= 3'h7;
			{sclMeta, sclS, sclP} <= 3'h7;
		end else begin
			{sdaMeta, sdaS, sdaP} <= {serialDataIn, sdaMeta, sdaS};
			{sclMeta, sclS, sclP} <= {serialClockIn, sclMeta, sclS};
		end
	end
	assign sclRise = sclS && !sclP;
	assign sclFall = !sclS && sclP;
	assign startDet = sclS && sclP && sdaP && !sdaS;
	assign stopDet = sclS && sclP && !sdaP && sdaS;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = !s_axi_rvalid;
	assign wrFire = s_axi_awready && s_axi_wstrb[0];
	assign wrCtrl2 = wrFire && s_axi_awaddr == spmc_pkg::CTRL2_OFF;
	assign wrBuf = wrFire && s_axi_awaddr == spmc_pkg::BUF_OFF && !busy;
	assign rdBuf = s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == spmc_pkg::BUF_OFF;
	assign wrHit = s_axi_awaddr inside {spmc_pkg::CTRL1_OFF,
		spmc_pkg::CTRL2_OFF, spmc_pkg::DIV_OFF, spmc_pkg::BUF_OFF,
		spmc_pkg::IRQ_STAT_OFF, spmc_pkg::IRQ_MASK_OFF};

	always_comb begin
		rdHit = 1'b1;
		case (s_axi_araddr)
			spmc_pkg::CTRL1_OFF: rdByte = {1'b0, receiveOverflowFlag,
				portEnable, 1'b0, portFunctionSelect};
			spmc_pkg::CTRL2_OFF: rdByte = {generalCallEnable,
				ackStatusFlag, ackLevelBit, goReg};
			spmc_pkg::DIV_OFF: rdByte = dividerOrAddressReg;
			spmc_pkg::BUF_OFF: rdByte = transferBuffer;
			spmc_pkg::IRQ_STAT_OFF: rdByte = {6'h00, irqStat};
			spmc_pkg::IRQ_MASK_OFF: rdByte = {6'h00, irqMask};
			default: begin
				rdByte = 8'h00;
				rdHit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= spmc_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= spmc_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? spmc_pkg::RESP_OKAY
					: spmc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rdByte};
				s_axi_rresp <= rdHit ? spmc_pkg::RESP_OKAY
					: spmc_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			{receiveOverflowFlag, portEnable, portFunctionSelect} <=
				{spmc_pkg::CTRL1_RESET[6:5], spmc_pkg::CTRL1_RESET[3:0]};
			dividerOrAddressReg <= spmc_pkg::DIV_RESET;
			irqMask <= spmc_pkg::IRQ_RESET;
		end else begin
			if (wrFire && s_axi_awaddr == spmc_pkg::CTRL1_OFF) begin
				portFunctionSelect <= s_axi_wdata[3:0];
				portEnable <= s_axi_wdata[spmc_pkg::C1_EN];
				if (!s_axi_wdata[spmc_pkg::C1_OVF])
					receiveOverflowFlag <= 1'b0;
			end
			// only slave reception can overflow; set beats clear
			if (sByteDone && bufFull)
				receiveOverflowFlag <= 1'b1;
			if (wrFire && s_axi_awaddr == spmc_pkg::DIV_OFF)
				dividerOrAddressReg <= s_axi_wdata[7:0];
			if (wrFire && s_axi_awaddr == spmc_pkg::IRQ_MASK_OFF)
				irqMask <= s_axi_wdata[1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			generalCallEnable <= spmc_pkg::CTRL2_RESET[spmc_pkg::C2_GENERAL_CALL_ENABLE];
			ackLevelBit <= spmc_pkg::CTRL2_RESET[spmc_pkg::C2_ACK_LEVEL_BIT];
			goReg <= spmc_pkg::CTRL2_RESET[4:0];
		end else begin
			if (wrCtrl2) begin
				generalCallEnable <= s_axi_wdata[spmc_pkg::C2_GENERAL_CALL_ENABLE];
				ackLevelBit <= s_axi_wdata[spmc_pkg::C2_ACK_LEVEL_BIT];
			end
			// plain stretch control outside master mode
			if (!masterMode) begin
				goReg[4:1] <= 4'h0;
				if (wrCtrl2)
					goReg[0] <= s_axi_wdata[spmc_pkg::C2_SEN];
			// one request at a time, none while busy
			end else if (wrCtrl2 && !busy) begin
				goReg <= s_axi_wdata[4:0] & (~s_axi_wdata[4:0] + 5'h01);
			// receive enable drops with the eighth bit
			end else if (seqDone) begin
				goReg <= 5'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Buffer and interrupts
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			transferBuffer <= 8'h00;
			bufFull <= 1'b0;
			txGo <= 1'b0;
			txByte <= 8'h00;
		end else begin
			if (rdBuf)
				bufFull <= 1'b0;
			if (wrBuf) begin
				transferBuffer <= s_axi_wdata[7:0];
				txByte <= s_axi_wdata[7:0];
				txGo <= masterMode;
			end
			if (seqDone && mState == M_TX)
				txGo <= 1'b0;
			if (seqDone && mState == M_RX) begin
				transferBuffer <= rxShift;
				bufFull <= 1'b1;
			end
			if (sByteDone && !bufFull) begin
				transferBuffer <= receiveShifter;
				bufFull <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			irqStat <= spmc_pkg::IRQ_RESET;
		end else begin
			irqStat <= (irqStat & ~((wrFire && s_axi_awaddr ==
				spmc_pkg::IRQ_STAT_OFF) ? s_axi_wdata[1:0] : 2'h0))
				| {sByteDone, seqDone};
		end
	end

	// ------------------------------------------------------------
	// Master engine, four ticks per bit
	// ------------------------------------------------------------
	// Quarter bit lasts divider plus one cycles
	always_ff @(posedge core_clk) begin
		if (!rstn || mState == M_IDLE || divCnt == 8'h00)
			divCnt <= dividerOrAddressReg;
		else
			divCnt <= divCnt - 8'h01;
	end
	assign tick = mState != M_IDLE && divCnt == 8'h00;
	assign lastBit = mState == M_TX ? bitCnt == spmc_pkg::LAST_TX_BIT
		: mState == M_RX ? bitCnt == spmc_pkg::LAST_RX_BIT : 1'b1;
	assign seqDone = tick && phase == 2'h3 && lastBit;

	always_ff @(posedge core_clk) begin
		if (!rstn || !masterMode) begin
			mState <= M_IDLE;
			phase <= 2'h0;
			bitCnt <= 4'h0;
			mSdaLow <= 1'b0;
			mSclLow <= 1'b0;
			rxShift <= 8'h00;
			ackStatusFlag <= 1'b0;
		end else if (mState == M_IDLE) begin
			phase <= 2'h0;
			bitCnt <= 4'h0;
			if (goReg[spmc_pkg::C2_SEN])
				mState <= M_START;
			else if (goReg[spmc_pkg::C2_REPEAT_START_GO])
				mState <= M_RSTART;
			else if (goReg[spmc_pkg::C2_PEN])
				mState <= M_STOP;
			else if (goReg[spmc_pkg::C2_MASTER_RECEIVE_GO])
				mState <= M_RX;
			else if (goReg[spmc_pkg::C2_ACK_SEQUENCE_GO])
				mState <= M_ACK;
			else if (txGo)
				mState <= M_TX;
		end else if (tick) begin
			phase <= phase + 2'h1;
			case (mState)
				// data falls while clock is high
				M_START: begin
					if (phase == 2'h0) {mSdaLow, mSclLow} <= 2'b00;
					if (phase == 2'h1) mSdaLow <= 1'b1;
					if (phase == 2'h2) mSclLow <= 1'b1;
				end
				M_RSTART: begin
					if (phase == 2'h0) {mSdaLow, mSclLow} <= 2'b01;
					if (phase == 2'h1) mSclLow <= 1'b0;
					if (phase == 2'h2) mSdaLow <= 1'b1;
				end
				// data rises while clock is high
				M_STOP: begin
					if (phase == 2'h0) {mSdaLow, mSclLow} <= 2'b11;
					if (phase == 2'h1) mSclLow <= 1'b0;
					if (phase == 2'h2) mSdaLow <= 1'b0;
				end
				default: begin
					if (phase == 2'h0) begin
						mSclLow <= 1'b1;
						// ack level chooses ACK or NACK
						mSdaLow <= mState == M_ACK ? !ackLevelBit
							: mState == M_TX && bitCnt != 4'h8
							&& !txByte[3'h7 - bitCnt[2:0]];
					end
					if (phase == 2'h1)
						mSclLow <= 1'b0;
					if (phase == 2'h2 && mState == M_TX && bitCnt == 4'h8)
						ackStatusFlag <= sdaS;
					if (phase == 2'h2 && mState == M_RX)
						rxShift <= {rxShift[6:0], sdaS};
					if (phase == 2'h3) begin
						mSclLow <= 1'b1;
						bitCnt <= bitCnt + 4'h1;
					end
				end
			endcase
			if (seqDone)
				mState <= M_IDLE;
		end
	end

	// ------------------------------------------------------------
	// Slave receive with address match
	// ------------------------------------------------------------
	// general call only counts when enabled
	assign addrMatch = (receiveShifter != spmc_pkg::GEN_CALL_ADDR
		&& receiveShifter[7:1] == dividerOrAddressReg[7:1])
		|| (generalCallEnable
		&& receiveShifter == spmc_pkg::GEN_CALL_ADDR);
	assign sAccept = sState == S_SHIFT && sclFall && sCnt == 4'h8;
	assign sByteDone = sAccept && (!addrPhase || addrMatch);

	always_ff @(posedge core_clk) begin
		if (!rstn || !slaveMode) begin
			sState <= S_IDLE;
			sCnt <= 4'h0;
			addrPhase <= 1'b0;
			receiveShifter <= 8'h00;
			sSdaLow <= 1'b0;
			sSclLow <= 1'b0;
		end else if (startDet) begin
			sState <= S_SHIFT;
			sCnt <= 4'h0;
			addrPhase <= 1'b1;
			sSdaLow <= 1'b0;
		end else if (stopDet) begin
			sState <= S_IDLE;
			sSdaLow <= 1'b0;
			sSclLow <= 1'b0;
		end else begin
			case (sState)
				S_SHIFT: begin
					if (sclRise && sCnt != 4'h8) begin
						receiveShifter <= {receiveShifter[6:0], sdaS};
						sCnt <= sCnt + 4'h1;
					end
					if (sAccept) begin
						sSdaLow <= sByteDone;
						sState <= sByteDone ? S_ACK : S_IDLE;
					end
				end
				S_ACK: if (sclFall) begin
					sSdaLow <= 1'b0;
					addrPhase <= 1'b0;
					sCnt <= 4'h0;
					// hold clock low until buffer is read
					sSclLow <= goReg[spmc_pkg::C2_SEN];
					sState <= goReg[spmc_pkg::C2_SEN] ? S_HOLD : S_SHIFT;
				end
				S_HOLD: if (!bufFull || !goReg[spmc_pkg::C2_SEN]) begin
					sSclLow <= 1'b0;
					sState <= S_SHIFT;
				end
				default: sState <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_master_no_ovf: assert property (@(posedge core_clk) disable iff (!rstn)
		masterMode && !receiveOverflowFlag |=> !receiveOverflowFlag)
		else $error("overflow set in master mode");
	a_gencall_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
		sAccept && addrPhase && !generalCallEnable
		&& receiveShifter == spmc_pkg::GEN_CALL_ADDR
		|-> !sByteDone ##1 sState == S_IDLE)
		else $error("general call answered while disabled");
	a_ack_status: assert property (@(posedge core_clk) disable iff (!rstn)
		tick && mState == M_TX && phase == 2'h2 && bitCnt == 4'h8
		|=> ackStatusFlag == $past(sdaS))
		else $error("ack status not from ack slot");
	a_ack_level: assert property (@(posedge core_clk) disable iff (!rstn)
		mState == M_ACK && phase != 2'h0 |-> serialDataOe == !ackLevelBit)
		else $error("wrong acknowledge level driven");
	a_stop_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		seqDone && mState == M_STOP
		|=> !goReg[spmc_pkg::C2_PEN] && mState == M_IDLE)
		else $error("stop request not cleared");
	a_start_edge: assert property (@(posedge core_clk) disable iff (!rstn)
		mState == M_START && phase == 2'h2 |-> serialDataOe && !mSclLow)
		else $error("start without data low under high clock");
	a_busy_blocks: assert property (@(posedge core_clk) disable iff (!rstn)
		masterMode && wrCtrl2 && busy && !seqDone |=> $stable(goReg))
		else $error("request accepted while busy");
	a_rx_clear: assert property (@(posedge core_clk) disable iff (!rstn)
		seqDone && mState == M_RX
		|=> !goReg[spmc_pkg::C2_MASTER_RECEIVE_GO] && bufFull)
		else $error("receive enable not cleared after byte");
	a_stretch_hold: assert property (@(posedge core_clk) disable iff (!rstn)
		sState == S_HOLD |-> serialClockOe && goReg[spmc_pkg::C2_SEN])
		else $error("clock not held while stretching");
endmodule

`default_nettype wire

// *** pkg/spmc_pkg.sv ***
// Purpose: Constants for the serial port mode and I2C master control block
// Assumes: AXI4-Lite register access, 32-bit data, byte registers
// Notes: Offsets are byte addresses, one aligned word per register
package spmc_pkg;
	// Register offsets
	localparam logic [7:0] CTRL1_OFF = 8'h00;
	localparam logic [7:0] CTRL2_OFF = 8'h04;
	localparam logic [7:0] DIV_OFF = 8'h08;
	localparam logic [7:0] BUF_OFF = 8'h0C;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h14;
	// Port function codes
	localparam logic [3:0] MODE_SPI_FAST = 4'h0;
	localparam logic [3:0] MODE_I2C_SLAVE7 = 4'h6;
	localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
	localparam logic [3:0] MODE_SPI_DIV = 4'hA;
	localparam logic [3:0] MODE_I2C_FW = 4'hB;
	// First control register fields
	localparam int C1_EN = 5;
	localparam int C1_OVF = 6;
	// Second control register fields
	localparam int C2_GENERAL_CALL_ENABLE = 7;
	localparam int C2_ACK_STATUS_FLAG = 6;
	localparam int C2_ACK_LEVEL_BIT = 5;
	localparam int C2_ACK_SEQUENCE_GO = 4;
	localparam int C2_MASTER_RECEIVE_GO = 3;
	localparam int C2_PEN = 2;
	localparam int C2_REPEAT_START_GO = 1;
	localparam int C2_SEN = 0;
	// Interrupt status bits
	localparam int IRQ_OP_DONE = 0;
	localparam int IRQ_SLAVE_RX = 1;
	// Reset values
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	localparam logic [7:0] CTRL2_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// Bus answers and fixed codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [3:0] LAST_TX_BIT = 4'h8;
	localparam logic [3:0] LAST_RX_BIT = 4'h7;
endpackage

// *** tb/serial_port_mode_and_i2c_master_control_test.sv ***
// Purpose: Register-level test of mode select and I2C master events
// Assumes: Divider 3, peer model on the wires with pull-ups
// Notes: The bench also drives the wires as controller for slave tests
`timescale 1ns/1ps
`default_nettype none
module serial_port_mode_and_i2c_master_control_test;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, d;
	logic sdaOe, sclOe, sdaWire, sclWire, peerPull;
	logic tbSdaLow = 1'b0, tbSclLow = 1'b0, ackSeen, sdaOut, sclOut;
	logic ackOn = 1'b1;
	logic readMode = 1'b0;
	int n_errors = 0;
	int checks = 0;

	// ----------------------------------------
	// Open-drain wires with pull-ups
	// ----------------------------------------
	assign sdaWire = !(sdaOe | peerPull | tbSdaLow);
	assign sclWire = !(sclOe | tbSclLow);

	initial begin
		forever #2.5 core_clk = !core_clk;
	end

	spmc_serial_ctrl spmc_serial_ctrl_i (.core_clk(core_clk),
		.rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .serialDataIn(sdaWire),
		.serialDataOut(sdaOut), .serialDataOe(sdaOe),
		.serialClockIn(sclWire), .serialClockOut(sclOut),
		.serialClockOe(sclOe), .irq(irq));

	spmc_i2c_peer spmc_i2c_peer_i (.core_clk(core_clk),
		.sclWire(sclWire), .sdaWire(sdaWire), .ackOn(ackOn),
		.readMode(readMode), .txByte(8'h5A), .sdaPull(peerPull));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task complete_run;
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic hang;
		n_errors++;
		$display("CHECK FAILED %0t timeout", $time);
		complete_run;
	endtask

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!(awready === 1'b1 && wready === 1'b1) && n < 99);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (bvalid !== 1'b1 && n < 99);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 99)
			hang;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (arready !== 1'b1 && n < 99);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (rvalid !== 1'b1 && n < 99);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
		if (n >= 99)
			hang;
	endtask

	// ----------------------------------------
	// Bench as bus controller for slave tests
	// ----------------------------------------
	task automatic pins(input logic c, input logic s);
		tbSclLow <= c;
		tbSdaLow <= s;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic bus_start;
		pins(1'b0, 1'b1);
		pins(1'b1, 1'b1);
	endtask

	task automatic bus_stop;
		pins(1'b1, 1'b1);
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
	endtask

	// Eight bits MSB first, then a released acknowledge slot
	task automatic bb(input logic [7:0] v);
		logic [8:0] w;
		w = {v, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			pins(1'b1, !w[i]);
			pins(1'b0, !w[i]);
			if (i == 0)
				ackSeen = !sdaWire;
		end
		pins(1'b1, 1'b0);
	endtask

	// Polls status; the engine takes well under 300 polls per byte
	task automatic op(input logic [7:0] a, input logic [31:0] v,
		input logic [7:0] c2, input logic ei);
		int n;
		wr(a, v);
		for (n = 0; n < 300; n++) begin
			rd(spmc_pkg::IRQ_STAT_OFF);
			if (d[0] === 1'b1)
				break;
		end
		if (n >= 300)
			hang;
		chk(32'(irq), 32'(ei));
		rd(spmc_pkg::CTRL2_OFF);
		chk(d, 32'(c2));
		wr(spmc_pkg::IRQ_STAT_OFF, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			if (i != 3) begin
				rd(8'(i * 4));
				chk(d, 32'h0000_0000);
			end
		end
		rd(8'h40);
		chk(32'(resp), 32'(spmc_pkg::RESP_SLVERR));
		wr(spmc_pkg::DIV_OFF, 32'h0000_0003);
		for (int i = 0; i < 14; i++) begin
			wr(spmc_pkg::CTRL1_OFF, 32'(i));
			rd(spmc_pkg::CTRL1_OFF);
			chk(32'(d[3:0]), 32'(i));
		end
		wr(spmc_pkg::IRQ_MASK_OFF, 32'h0000_0001);
		wr(spmc_pkg::CTRL1_OFF, 32'h0000_0028);
		op(spmc_pkg::CTRL2_OFF, 32'h0000_0001, 8'h00, 1'b1);
		// Stop request written while the address byte is shifting is ignored
		wr(spmc_pkg::BUF_OFF, 32'h0000_00A1);
		op(spmc_pkg::CTRL2_OFF, 32'h0000_0004, 8'h00, 1'b1);
		readMode <= 1'b1;
		op(spmc_pkg::CTRL2_OFF, 32'h0000_0008, 8'h00, 1'b1);
		rd(spmc_pkg::BUF_OFF);
		chk(d, 32'h0000_005A);
		rd(spmc_pkg::CTRL1_OFF);
		chk(32'(d[spmc_pkg::C1_OVF]), 32'h0000_0000);
		readMode <= 1'b0;
		ackOn <= 1'b0;
		op(spmc_pkg::CTRL2_OFF, 32'h0000_0030, 8'h20, 1'b1);
		// Writing the register again also rewrites the ack level
		op(spmc_pkg::CTRL2_OFF, 32'h0000_0002, 8'h00, 1'b1);
		wr(spmc_pkg::BUF_OFF, 32'h0000_00A0);
		op(spmc_pkg::CTRL2_OFF, 32'h0000_0004, 8'h40, 1'b1);
		wr(spmc_pkg::IRQ_MASK_OFF, 32'h0000_0000);
		op(spmc_pkg::CTRL2_OFF, 32'h0000_0004, 8'h40, 1'b0);
		chk(32'({sdaWire, sclWire}), 32'h0000_0003);
		// Slave receive, own address 0x42 held in the divider
		wr(spmc_pkg::DIV_OFF, 32'h0000_0084);
		wr(spmc_pkg::CTRL1_OFF, 32'h0000_0026);
		wr(spmc_pkg::IRQ_MASK_OFF, 32'h0000_0002);
		bus_start;
		bb(8'h00);
		chk(32'(ackSeen), 32'h0000_0000);
		bus_stop;
		chk(32'(irq), 32'h0000_0000);
		wr(spmc_pkg::CTRL2_OFF, 32'h0000_0080);
		bus_start;
		bb(8'h00);
		chk(32'(ackSeen), 32'h0000_0001);
		pins(1'b0, 1'b0);
		chk(32'(sclWire), 32'h0000_0001);
		bus_stop;
		chk(32'(irq), 32'h0000_0001);
		rd(spmc_pkg::BUF_OFF);
		chk(d, 32'h0000_0000);
		wr(spmc_pkg::IRQ_STAT_OFF, 32'h0000_0002);
		// Stretching holds the clock low until the buffer is read
		wr(spmc_pkg::CTRL2_OFF, 32'h0000_0081);
		bus_start;
		bb(8'h84);
		chk(32'(ackSeen), 32'h0000_0001);
		pins(1'b0, 1'b0);
		chk(32'(sclWire), 32'h0000_0000);
		rd(spmc_pkg::BUF_OFF);
		chk(d, 32'h0000_0084);
		pins(1'b0, 1'b0);
		chk(32'(sclWire), 32'h0000_0001);
		bus_stop;
		chk(32'(irq), 32'h0000_0001);
		chk(32'({sdaOut, sclOut}), 32'h0000_0000);
		wr(8'h40, 32'h0000_0000);
		chk(32'(resp), 32'(spmc_pkg::RESP_SLVERR));
		complete_run;
	end
endmodule
`default_nettype wire

// *** tb/spmc_i2c_peer.sv ***
// Purpose: Behavioural I2C target on the open-drain data and clock wires
// Assumes: Wires sampled on core_clk, much faster than the serial clock
// Notes: Acks the address byte; in read mode shifts out txByte MSB first
`timescale 1ns/1ps
`default_nettype none
module spmc_i2c_peer (
	input wire logic core_clk,
	input wire logic sclWire,
	input wire logic sdaWire,
	input wire logic ackOn,
	input wire logic readMode,
	input wire logic [7:0] txByte,
	output logic sdaPull
);
	logic sclPrev = 1'b1;
	logic sdaPrev = 1'b1;
	int cnt = 99;

	// Combinational so the bench can release the line between phases
	function automatic logic drive(int k, logic ack, logic rdm,
		logic [7:0] b);
		if (k < 0 || k > 90)
			return 1'b0;
		if (k % 9 == 8)
			return ack && (k < 9 || !rdm);
		return rdm && k > 8 && !b[7 - k % 9];
	endfunction

	assign sdaPull = drive(cnt, ackOn, readMode, txByte);

	// Bit framing restarts on every start and ends on stop
	always @(posedge core_clk) begin
		sclPrev <= sclWire;
		sdaPrev <= sdaWire;
		if (sclWire && sclPrev && sdaPrev && !sdaWire)
			cnt <= -1;
		else if (sclWire && sclPrev && !sdaPrev && sdaWire)
			cnt <= 99;
		else if (sclPrev && !sclWire && cnt < 90)
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire
